/* File: logic/uei_pkg.sv */
//------------------------------------------------------------------------------
// What this block does
//------------------------------------------------------------------------------
// What this block does
// - Host detach interrupt forwarded only when enabled.
// - Error flags reach interrupt only with summary enable.
// - Sticky error flags, zero at reset, write-one clears.
// - Status and enable bits 31 to 8 read zero.
// - Bit stuffing violation sets status bit 7.
// - Invalid descriptor or buffer address sets bit 6.
// - Memory overrun, underrun or truncation sets bit 5.
// - Over 16 idle bit times sets bit 4.
// - Non-byte data field length sets bit 3.
// - Data CRC16 failure sets status bit 2.
// - Device mode token CRC5 failure sets bit 1.
// - Host mode frame end overrun sets bit 1.
// - Packet identifier check failure sets bit 0.
// - Enable bits 7 to 0, reset zero, gate flags.
// - Enable bit 1 follows mode meaning of bit 1.
// - Summary flag set when any unmasked error exists.
// - Host mode detach detection raises detach flag.
package uei_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ERR_FLAGS_OFS     = 8'h00;
  localparam logic [7:0]  ERR_MASK_OFS      = 8'h04;
  localparam logic [7:0]  MAIN_IRQ_EN_OFS   = 8'h08;
  localparam logic [7:0]  MAIN_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0]  MODE_CTRL_OFS     = 8'h10;

  localparam logic [7:0]  ERR_FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  ERR_MASK_RESET    = 8'h00;
  localparam logic [1:0]  MAIN_IRQ_RESET    = 2'h0;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int STUFF_BIT       = 7;
  localparam int BMX_BIT         = 6;
  localparam int MEM_BIT         = 5;
  localparam int TURNAROUND_BIT  = 4;
  localparam int FIELD_SIZE_BIT  = 3;
  localparam int DATA_CRC_BIT    = 2;
  localparam int TOKEN_FRAME_BIT = 1;
  localparam int PID_BIT         = 0;
  localparam int DETACH_BIT      = 0;
  localparam int SUMMARY_BIT     = 1;
  localparam int HOST_MODE_BIT   = 3;
  localparam int ERR_WIDTH       = 8;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          TURNAROUND_BIT_TIMES = 16;
  localparam logic [4:0]  TURNAROUND_LIMIT     = 5'(TURNAROUND_BIT_TIMES);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    TA_IDLE = 1'b0,
    TA_WAIT = 1'b1
  } uei_ta_state_type;

  typedef struct packed {
    logic stuff_err;
    logic bmx_addr_err;
    logic mem_access_err;
    logic field_size_err;
    logic data_crc_fail;
    logic token_crc_fail;
    logic sof_count_zero;
    logic link_busy;
    logic pid_fail;
  } uei_evt_type;

  typedef struct packed {
    logic eop_done;
    logic bit_tick;
    logic response_start;
  } uei_turn_type;

endpackage : uei_pkg

/* File: logic/uei_top.sv */
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module uei_top (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  input  wire uei_pkg::uei_evt_type  evt,
  input  wire uei_pkg::uei_turn_type turn,
  input  wire logic                  peer_detach_evt,
  output logic                       usb_module_irq_line,
  output logic                       error_summary_flag,
  output logic                       host_mode
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic                          wr_flags;
  logic                          wr_mask;
  logic                          wr_main_en;
  logic                          wr_main_stat;
  logic                          wr_mode;
  logic [uei_pkg::ERR_WIDTH-1:0] err_flags_q;
  logic [uei_pkg::ERR_WIDTH-1:0] err_set;
  logic [uei_pkg::ERR_WIDTH-1:0] err_mask_q;
  logic [1:0]                    main_en_q;
  logic                          peer_disconnect_flag_q;
  logic                          host_mode_q;
  logic                          summary_d;
  logic                          summary_q;
  logic                          irq_q;
  logic [31:0]                   rdata_q;
  uei_pkg::uei_ta_state_type     ta_state_q;
  logic [4:0]                    ta_count_q;
  logic                          ta_timeout;

  assign wr_flags     = reg_write && hit(reg_addr, uei_pkg::ERR_FLAGS_OFS);
  assign wr_mask      = reg_write && hit(reg_addr, uei_pkg::ERR_MASK_OFS);
  assign wr_main_en   = reg_write && hit(reg_addr, uei_pkg::MAIN_IRQ_EN_OFS);
  assign wr_main_stat = reg_write && hit(reg_addr, uei_pkg::MAIN_IRQ_STAT_OFS);
  assign wr_mode      = reg_write && hit(reg_addr, uei_pkg::MODE_CTRL_OFS);

  // ---------------------------------------------------------------------------
  // Bus turnaround timer
  // ---------------------------------------------------------------------------
  // Counts bit times after an end of packet while a reply is awaited. A new
  // end of packet restarts the count so back-to-back packets are measured
  // from the latest one.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ta_state_q <= uei_pkg::TA_IDLE;
      ta_count_q <= 5'h00;
    end else begin
      case (ta_state_q)
        uei_pkg::TA_IDLE: begin
          if (turn.eop_done) begin
            ta_state_q <= uei_pkg::TA_WAIT;
            ta_count_q <= 5'h00;
          end
        end
        uei_pkg::TA_WAIT: begin
          if (turn.eop_done) begin
            ta_count_q <= 5'h00;
          end else if (turn.response_start || ta_timeout) begin
            ta_state_q <= uei_pkg::TA_IDLE;
          end else if (turn.bit_tick) begin
            ta_count_q <= ta_count_q + 5'h01;
          end
        end
        default: begin
          ta_state_q <= uei_pkg::TA_IDLE;
          ta_count_q <= 5'h00;
        end
      endcase
    end
  end

  // More than the limit means the tick that lifts the count past it.
  assign ta_timeout = (ta_state_q == uei_pkg::TA_WAIT) && !turn.eop_done && !turn.response_start
                      && turn.bit_tick && (ta_count_q == uei_pkg::TURNAROUND_LIMIT);

  // ---------------------------------------------------------------------------
  // Error set sources
  // ---------------------------------------------------------------------------
  always_comb begin
    err_set                            = '0;
    err_set[uei_pkg::STUFF_BIT]        = evt.stuff_err;
    err_set[uei_pkg::BMX_BIT]          = evt.bmx_addr_err;
    err_set[uei_pkg::MEM_BIT]          = evt.mem_access_err;
    err_set[uei_pkg::TURNAROUND_BIT]   = ta_timeout;
    err_set[uei_pkg::FIELD_SIZE_BIT]   = evt.field_size_err;
    err_set[uei_pkg::DATA_CRC_BIT]     = evt.data_crc_fail;
    // Bit 1 changes meaning with the mode.
    err_set[uei_pkg::TOKEN_FRAME_BIT]  = host_mode_q ? (evt.sof_count_zero && evt.link_busy)
                                                     : evt.token_crc_fail;
    err_set[uei_pkg::PID_BIT]          = evt.pid_fail;
  end

  // ---------------------------------------------------------------------------
  // Sticky error flags
  // ---------------------------------------------------------------------------
  // A set in the same cycle as a clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < uei_pkg::ERR_WIDTH; gi++) begin : g_flag
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          err_flags_q[gi] <= uei_pkg::ERR_FLAGS_RESET[gi];
        end else if (err_set[gi]) begin
          err_flags_q[gi] <= 1'b1;
        end else if (wr_flags && reg_wdata[gi]) begin
          err_flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Enables and mode
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      err_mask_q <= uei_pkg::ERR_MASK_RESET;
    end else if (wr_mask) begin
      err_mask_q <= reg_wdata[uei_pkg::ERR_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      main_en_q <= uei_pkg::MAIN_IRQ_RESET;
    end else if (wr_main_en) begin
      main_en_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      host_mode_q <= 1'b0;
    end else if (wr_mode) begin
      host_mode_q <= reg_wdata[uei_pkg::HOST_MODE_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Detach flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      peer_disconnect_flag_q <= 1'b0;
    end else if (host_mode_q && peer_detach_evt) begin
      peer_disconnect_flag_q <= 1'b1;
    end else if (wr_main_stat && reg_wdata[uei_pkg::DETACH_BIT]) begin
      peer_disconnect_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Summary and interrupt line
  // ---------------------------------------------------------------------------
  assign summary_d = |(err_flags_q & err_mask_q);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      summary_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      summary_q <= summary_d;
      irq_q     <= (summary_d && main_en_q[uei_pkg::SUMMARY_BIT])
                   || (host_mode_q && peer_disconnect_flag_q && main_en_q[uei_pkg::DETACH_BIT]);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // Unmapped offsets and all unimplemented bits read as zero.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        uei_pkg::ERR_FLAGS_OFS:     rdata_q <= {24'h00_0000, err_flags_q};
        uei_pkg::ERR_MASK_OFS:      rdata_q <= {24'h00_0000, err_mask_q};
        uei_pkg::MAIN_IRQ_EN_OFS:   rdata_q <= {30'h0000_0000, main_en_q};
        uei_pkg::MAIN_IRQ_STAT_OFS: rdata_q <= {30'h0000_0000, summary_q, peer_disconnect_flag_q};
        uei_pkg::MODE_CTRL_OFS:     rdata_q <= {28'h000_0000, host_mode_q, 3'h0};
        default:                    rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata           = rdata_q;
  assign usb_module_irq_line = irq_q;
  assign error_summary_flag  = summary_q;
  assign host_mode           = host_mode_q;

endmodule : uei_top

/* File: tb/uei_asserts.sv */
`timescale 1ns/100ps
module uei_asserts (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic [7:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_write,
  input wire logic                   reg_read,
  input wire logic [31:0]            reg_rdata,
  input wire uei_pkg::uei_evt_type   evt,
  input wire uei_pkg::uei_turn_type  turn,
  input wire logic                   peer_detach_evt,
  input wire logic                   usb_module_irq_line,
  input wire logic                   error_summary_flag,
  input wire logic                   host_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data not idle");
  upper_zero_a: assert property (reg_read && reg_addr <= uei_pkg::ERR_MASK_OFS |=> reg_rdata[31:8] == 24'h0)
    else $error("upper bits not zero");
  unmapped_zero_a: assert property (reg_read && reg_addr > uei_pkg::MODE_CTRL_OFS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  irq_cause_a: assert property (usb_module_irq_line |-> error_summary_flag || host_mode || $past(host_mode))
    else $error("interrupt without cause");
  summary_cause_a: assert property ($rose(error_summary_flag) |-> $past(reg_write, 2) || $past(|evt, 2)
    || $past(turn.bit_tick, 2)) else $error("summary rose without cause");
  summary_hold_a: assert property (error_summary_flag && !reg_write && !$past(reg_write) |=> error_summary_flag)
    else $error("summary dropped without write");
  reset_clear_a: assert property ($rose(reset_n) |-> !error_summary_flag && !usb_module_irq_line && !host_mode)
    else $error("outputs not clear after reset");
  host_write_a: assert property (reg_write && reg_addr == uei_pkg::MODE_CTRL_OFS
    |=> host_mode == $past(reg_wdata[uei_pkg::HOST_MODE_BIT])) else $error("mode bit not written");
  cover property ($rose(usb_module_irq_line));
  cover property ($rose(host_mode));
  cover property (reg_read && reg_addr == uei_pkg::ERR_FLAGS_OFS ##1 reg_rdata != 32'h0);
endmodule : uei_asserts
bind uei_top uei_asserts u_chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .evt(evt), .turn(turn),
  .peer_detach_evt(peer_detach_evt), .usb_module_irq_line(usb_module_irq_line),
  .error_summary_flag(error_summary_flag), .host_mode(host_mode));

/* File: tb/uei_link_model.sv */
`timescale 1ns/100ps
module uei_link_model (
  input wire logic               clock,
  input wire logic               go,
  input wire logic [4:0]         ticks,
  input wire logic               respond,
  output uei_pkg::uei_turn_type  turn,
  output logic                   busy
);
  // Three clocks per bit time is near full speed; only the count of ticks matters.
  initial begin
    turn = '0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy <= 1'b1;
        turn.eop_done <= 1'b1;
        @(posedge clock);
        turn <= '0;
        for (int i = 1; i <= ticks; i++) begin
          repeat (2) @(posedge clock);
          if (respond && i == 8) turn.response_start <= 1'b1;
          else turn.bit_tick <= 1'b1;
          @(posedge clock);
          turn <= '0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : uei_link_model

/* File: tb/usb_error_interrupt_logic_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module usb_error_interrupt_logic_tb;
  localparam logic [7:0] FL = uei_pkg::ERR_FLAGS_OFS;
  localparam logic [7:0] MK = uei_pkg::ERR_MASK_OFS;
  localparam logic [7:0] EN = uei_pkg::MAIN_IRQ_EN_OFS;
  localparam logic [7:0] ST = uei_pkg::MAIN_IRQ_STAT_OFS;
  localparam logic [7:0] MD = uei_pkg::MODE_CTRL_OFS;
  logic                  clock = 1'b0;
  logic                  reset_n = 1'b0;
  logic [7:0]            reg_addr = 8'h00;
  logic [31:0]           reg_wdata = 32'h0;
  logic                  reg_write = 1'b0;
  logic                  reg_read = 1'b0;
  logic [31:0]           reg_rdata;
  uei_pkg::uei_evt_type  evt = '0;
  uei_pkg::uei_turn_type turn;
  logic                  detach = 1'b0;
  logic                  irq;
  logic                  summary;
  logic                  host_mode;
  logic                  go = 1'b0;
  logic [4:0]            ticks = 5'h00;
  logic                  respond = 1'b0;
  logic                  lm_busy;
  int                    fail_count = 0;
  int                    check_count = 0;
  always #12.5 clock = ~clock;
  uei_top DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .evt(evt), .turn(turn), .peer_detach_evt(detach),
    .usb_module_irq_line(irq), .error_summary_flag(summary), .host_mode(host_mode));
  uei_link_model u_link (.clock(clock), .go(go), .ticks(ticks), .respond(respond), .turn(turn), .busy(lm_busy));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rdc
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic pulse(input logic [8:0] e, input logic d);
    @(posedge clock);
    evt <= uei_pkg::uei_evt_type'(e);
    detach <= d;
    @(posedge clock);
    evt <= '0;
    detach <= 1'b0;
    settle();
  endtask : pulse
  task automatic run(input logic [4:0] n, input logic r);
    @(posedge clock);
    go <= 1'b1;
    ticks <= n;
    respond <= r;
    @(posedge clock);
    go <= 1'b0;
    #1;
    for (int k = 0; k < 200 && lm_busy; k++) @(posedge clock);
    `CHK(lm_busy, 1'b0)
    if (lm_busy) begin
      conclude();
    end
  endtask : run
  task automatic t_regs;
    rdc(FL, 32'h0);
    rdc(MK, 32'h0);
    wr(MK, 32'hFFFF_FFFF);
    rdc(MK, 32'h0000_00FF);
    wr(FL, 32'hFFFF_FFFF);
    rdc(FL, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_events;
    int ev[7] = '{8, 7, 6, 5, 4, 3, 0};
    int fl[7] = '{7, 6, 5, 3, 2, 1, 0};
    wr(EN, 32'h2);
    rdc(EN, 32'h2);
    for (int i = 0; i < 7; i++) begin
      pulse(9'h1 << ev[i], 1'b0);
      `CHK(summary, 1'b1)
      `CHK(irq, 1'b1)
      rdc(FL, 32'h1 << fl[i]);
      wr(FL, ~(32'h1 << fl[i]));
      rdc(FL, 32'h1 << fl[i]);
      wr(FL, 32'h1 << fl[i]);
      rdc(FL, 32'h0);
      `CHK(summary, 1'b0)
    end
    pulse(9'h006, 1'b0);
    rdc(FL, 32'h0);
    $display("t_events done");
  endtask : t_events
  task automatic t_mask;
    wr(MK, 32'hFE);
    pulse(9'h001, 1'b0);
    `CHK(summary, 1'b0)
    wr(MK, 32'hFF);
    settle();
    `CHK(irq, 1'b1)
    wr(EN, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    `CHK(summary, 1'b1)
    wr(FL, 32'hFF);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_host;
    wr(MD, 32'h8);
    wr(EN, 32'h2);
    #1;
    `CHK(host_mode, 1'b1)
    rdc(MD, 32'h8);
    pulse(9'h008, 1'b0);
    rdc(FL, 32'h0);
    wr(MK, 32'hFD);
    pulse(9'h006, 1'b0);
    `CHK(summary, 1'b0)
    wr(MK, 32'hFF);
    settle();
    `CHK(irq, 1'b1)
    rdc(FL, 32'h2);
    wr(FL, 32'h2);
    pulse(9'h004, 1'b0);
    rdc(FL, 32'h0);
    wr(EN, 32'h1);
    pulse(9'h000, 1'b1);
    `CHK(irq, 1'b1)
    rdc(ST, 32'h1);
    wr(ST, 32'h1);
    wr(EN, 32'h0);
    pulse(9'h000, 1'b1);
    `CHK(irq, 1'b0)
    wr(ST, 32'h1);
    wr(MD, 32'h0);
    pulse(9'h000, 1'b1);
    rdc(ST, 32'h0);
    $display("t_host done");
  endtask : t_host
  task automatic t_turn;
    run(5'h10, 1'b0);
    rdc(FL, 32'h0);
    run(5'h11, 1'b0);
    rdc(FL, 32'h10);
    wr(FL, 32'h10);
    run(5'h14, 1'b1);
    rdc(FL, 32'h0);
    $display("t_turn done");
  endtask : t_turn
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_events();
    t_mask();
    t_host();
    t_turn();
    conclude();
  end
endmodule : usb_error_interrupt_logic_tb
